/* rtl/stc_scan_tap.sv */
// Purpose: test access port with 20-bit signature and count-up run mode
// Assumes: tck, tms, tdi and all pins are asynchronous to sys_clk_i
// Notes:   tck must be far slower than sys_clk_i; edges are found here
`default_nettype none

// What this block does
// - in signature/count run, fold input-side pins into a 20-bit signature.
// - output-side cells count up each rise unless the stream buffer is full; shadow and pins follow next fall.
// - output enables pick which side signs and which side counts.
// - tdi, tms and pins are sampled on the rising test clock.
// - tdo and output pins change only on the falling test clock.
// - leaving capture-ir loads 10000001 into the instruction shifter.
// - tdo enables on first fall in a shift state; one bit per rise.
// - last instruction bit enters on the shift-ir to exit1-ir rise.
// - tdo returns to high impedance on the fall in exit1.
// - update-ir fall loads the instruction; all ones means bypass.
// - under bypass, the bypass bit captures 0 leaving capture-dr.
// - bypass delays tdi to tdo by one stage.
// - update-dr fall moves shifted data into the parallel stage.
// - control code 111 selects signature/count mode.
// - run mode acts only under run-test instruction in run-test/idle.
// - run mode needs the two output enables to differ.
module stc_scan_tap
    import stc_pkg::*;
(
    // clock and reset
    input  wire  logic             sys_clk_i,
    input  wire  logic             sys_rst_i,
    // test access port
    input  wire  logic             tck_i,
    input  wire  logic             tms_i,
    input  wire  logic             tdi_i,
    output logic                   tdo_o,
    output logic                   tdo_oe_o,
    // direction controls, active low
    input  wire  logic             a_to_b_output_enable_n_i,
    input  wire  logic             b_to_a_output_enable_n_i,
    // a and b side pins
    input  wire  logic [SIG_W-1:0] a_pin_i,
    output logic       [SIG_W-1:0] a_pin_o,
    output logic       [SIG_W-1:0] a_pin_oe_o,
    input  wire  logic [SIG_W-1:0] b_pin_i,
    output logic       [SIG_W-1:0] b_pin_o,
    output logic       [SIG_W-1:0] b_pin_oe_o,
    // signature stream
    output logic                   sig_valid_o,
    input  wire  logic             sig_ready_i,
    output logic       [SIG_W-1:0] sig_data_o
);

    // pin sampling
    logic [SYN_W-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt;
    logic             tck_rise, tck_fall, tms, tdi, dir_ab, one_dir;
    logic [SIG_W-1:0] pin_a, pin_b;

    assign flt_nxt  = stc_agree(s2_r, s3_r, flt_r);
    assign tck_rise = flt_nxt[POS_TCK] & ~flt_r[POS_TCK];
    assign tck_fall = ~flt_nxt[POS_TCK] & flt_r[POS_TCK];
    assign tms      = flt_r[POS_TMS];
    assign tdi      = flt_r[POS_TDI];
    assign pin_a    = flt_r[POS_A +: SIG_W];
    assign pin_b    = flt_r[POS_B +: SIG_W];
    assign one_dir  = flt_r[POS_A_TO_B_OUTPUT_ENABLE] ^ flt_r[POS_B_TO_A_OUTPUT_ENABLE];
    assign dir_ab   = ~flt_r[POS_A_TO_B_OUTPUT_ENABLE] & flt_r[POS_B_TO_A_OUTPUT_ENABLE];

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s1_r  <= SYN_RST;
            s2_r  <= SYN_RST;
            s3_r  <= SYN_RST;
            flt_r <= SYN_RST;
        end else begin
            s1_r  <= {tck_i, tms_i, tdi_i, a_to_b_output_enable_n_i,
                      b_to_a_output_enable_n_i, b_pin_i, a_pin_i};
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flt_r <= flt_nxt;
        end
    end

    // tap state and registers
    stc_tap_e         state_r, state_nxt;
    logic [IR_W-1:0]  ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
    logic             byp_r, byp_nxt;
    logic [TCR_W-1:0] tcr_sh_r, tcr_sh_nxt, tcr_r, tcr_nxt;
    logic [BSR_W-1:0] bsr_sh_r, bsr_sh_nxt, bsr_shd_r, bsr_shd_nxt;
    logic             tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
    logic [BSR_W-1:0] pin_r, pin_nxt, pin_oe_r, pin_oe_nxt;
    logic             run_ok, step, buf_rdy, test_drive;
    logic [SIG_W-1:0] sig_in, sig_cur, sig_new, cnt_cur, cnt_new;

    // run mode gate: instruction, idle state, code and single direction
    assign run_ok = (ir_r == IR_RUN_TEST) && (state_r == TAP_IDLE)
                    && (tcr_r == TCR_SIG_COUNT) && one_dir;
    // a full stream buffer skips the step; the seed is never corrupted
    assign step   = tck_rise & run_ok & buf_rdy;
    assign test_drive = (ir_r == IR_RUN_TEST) && one_dir;

    // a->b flow: a side signs, b side counts; reversed otherwise
    assign sig_in  = dir_ab ? pin_a : pin_b;
    assign sig_cur = dir_ab ? bsr_sh_r[POS_A +: SIG_W]
                            : bsr_sh_r[POS_B +: SIG_W];
    assign cnt_cur = dir_ab ? bsr_sh_r[POS_B +: SIG_W]
                            : bsr_sh_r[POS_A +: SIG_W];
    assign sig_new = {sig_cur[SIG_W-2:0], ^(sig_cur & SIG_TAPS)}
                     ^ sig_in;
    assign cnt_new = cnt_cur + 20'h00001;

    always_comb begin
        state_nxt   = state_r;
        ir_sh_nxt   = ir_sh_r;
        ir_nxt      = ir_r;
        byp_nxt     = byp_r;
        tcr_sh_nxt  = tcr_sh_r;
        tcr_nxt     = tcr_r;
        bsr_sh_nxt  = bsr_sh_r;
        bsr_shd_nxt = bsr_shd_r;
        tdo_nxt     = tdo_r;
        tdo_oe_nxt  = tdo_oe_r;
        pin_nxt     = pin_r;
        pin_oe_nxt  = pin_oe_r;
        if (tck_rise) begin
            state_nxt = stc_tap_next(state_r, tms);
            unique case (state_r)
                TAP_CAP_IR: ir_sh_nxt = IR_CAPTURE;
                TAP_SH_IR:  ir_sh_nxt = {tdi, ir_sh_r[IR_W-1:1]};
                TAP_CAP_DR: byp_nxt   = 1'b0;
                TAP_SH_DR: begin
                    byp_nxt = tdi;
                    if (ir_r == IR_BND_READ) begin
                        bsr_sh_nxt = {tdi, bsr_sh_r[BSR_W-1:1]};
                    end else if (ir_r == IR_TCR_SCAN) begin
                        tcr_sh_nxt = {tdi, tcr_sh_r[TCR_W-1:1]};
                    end
                end
                default: ;
            endcase
            if (step) begin
                if (dir_ab) begin
                    bsr_sh_nxt = {cnt_new, sig_new};
                end else begin
                    bsr_sh_nxt = {sig_new, cnt_new};
                end
            end
        end
        if (tck_fall) begin
            // tdo is live only through shift; exit1 turns it off
            tdo_oe_nxt = (state_r == TAP_SH_IR) || (state_r == TAP_SH_DR);
            if (state_r == TAP_SH_IR) begin
                tdo_nxt = ir_sh_r[0];
            end else if (state_r == TAP_SH_DR) begin
                if (ir_r == IR_BND_READ) begin
                    tdo_nxt = bsr_sh_r[0];
                end else if (ir_r == IR_TCR_SCAN) begin
                    tdo_nxt = tcr_sh_r[0];
                end else begin
                    tdo_nxt = byp_r;
                end
            end
            if (state_r == TAP_UPD_IR) begin
                ir_nxt = ir_sh_r;
            end
            if (state_r == TAP_UPD_DR) begin
                if (ir_r == IR_BND_READ) begin
                    bsr_shd_nxt = bsr_sh_r;
                end else if (ir_r == IR_TCR_SCAN) begin
                    tcr_nxt = tcr_sh_r;
                end
            end
            if (run_ok) begin
                if (dir_ab) begin
                    bsr_shd_nxt[POS_B +: SIG_W] = bsr_sh_r[POS_B +: SIG_W];
                end else begin
                    bsr_shd_nxt[POS_A +: SIG_W] = bsr_sh_r[POS_A +: SIG_W];
                end
            end
            pin_nxt    = bsr_shd_nxt;
            pin_oe_nxt = {{SIG_W{test_drive & dir_ab}},
                          {SIG_W{test_drive & ~dir_ab}}};
        end
        if (state_r == TAP_RESET) begin
            ir_nxt = IR_BYPASS;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r   <= TAP_RESET;
            ir_sh_r   <= IR_CAPTURE;
            ir_r      <= IR_BYPASS;
            byp_r     <= 1'b0;
            tcr_sh_r  <= TCR_RST;
            tcr_r     <= TCR_RST;
            bsr_sh_r  <= BSR_RST;
            bsr_shd_r <= BSR_RST;
            tdo_r     <= 1'b0;
            tdo_oe_r  <= 1'b0;
            pin_r     <= BSR_RST;
            pin_oe_r  <= BSR_RST;
        end else begin
            state_r   <= state_nxt;
            ir_sh_r   <= ir_sh_nxt;
            ir_r      <= ir_nxt;
            byp_r     <= byp_nxt;
            tcr_sh_r  <= tcr_sh_nxt;
            tcr_r     <= tcr_nxt;
            bsr_sh_r  <= bsr_sh_nxt;
            bsr_shd_r <= bsr_shd_nxt;
            tdo_r     <= tdo_nxt;
            tdo_oe_r  <= tdo_oe_nxt;
            pin_r     <= pin_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

    assign tdo_o      = tdo_r;
    assign tdo_oe_o   = tdo_oe_r;
    assign a_pin_o    = pin_r[POS_A +: SIG_W];
    assign b_pin_o    = pin_r[POS_B +: SIG_W];
    assign a_pin_oe_o = pin_oe_r[POS_A +: SIG_W];
    assign b_pin_oe_o = pin_oe_r[POS_B +: SIG_W];

    stc_skid2 #(.W(SIG_W)) u_sig_buf (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (tck_rise & run_ok),
        .in_ready_o  (buf_rdy),
        .in_data_i   (sig_new),
        .out_valid_o (sig_valid_o),
        .out_ready_i (sig_ready_i),
        .out_data_o  (sig_data_o)
    );

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_ir_capture;
        tck_rise && state_r == TAP_CAP_IR |=> ir_sh_r == IR_CAPTURE;
    endproperty
    a_ir_capture: assert property (p_ir_capture)
        else $error("capture-ir did not load 10000001");

    property p_tdo_on_fall;
        $changed(tdo_r) || $changed(tdo_oe_r) |-> $past(tck_fall);
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall)
        else $error("tdo moved away from a falling test clock");

    property p_tdo_off_exit1;
        tck_fall && (state_r == TAP_EX1_IR || state_r == TAP_EX1_DR)
        |=> !tdo_oe_r;
    endproperty
    a_tdo_off_exit1: assert property (p_tdo_off_exit1)
        else $error("tdo still enabled after exit1 fall");

    property p_byp_zero;
        tck_rise && state_r == TAP_CAP_DR |=> !byp_r;
    endproperty
    a_byp_zero: assert property (p_byp_zero)
        else $error("bypass bit did not capture zero");

    property p_upd_ir;
        tck_fall && state_r == TAP_UPD_IR |=> ir_r == $past(ir_sh_r);
    endproperty
    a_upd_ir: assert property (p_upd_ir)
        else $error("update-ir did not load the shifted instruction");

    property p_count_step;
        step && dir_ab |=> bsr_sh_r[POS_B +: SIG_W]
                           == $past(cnt_cur) + 20'h00001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not advance by one");

    property p_idle_only;
        tck_rise && state_r != TAP_SH_DR && !run_ok |=> $stable(bsr_sh_r);
    endproperty
    a_idle_only: assert property (p_idle_only)
        else $error("boundary cells changed outside run or shift");

    property p_one_dir;
        tck_fall && !one_dir |=> pin_oe_r == BSR_RST;
    endproperty
    a_one_dir: assert property (p_one_dir)
        else $error("pins driven with both directions alike");

    property p_pins_on_fall;
        $changed(pin_r) || $changed(bsr_shd_r) |-> $past(tck_fall);
    endproperty
    a_pins_on_fall: assert property (p_pins_on_fall)
        else $error("pins or shadow moved off a falling test clock");

    property p_state_on_rise;
        $changed(state_r) && !$past(sys_rst_i) |-> $past(tck_rise);
    endproperty
    a_state_on_rise: assert property (p_state_on_rise)
        else $error("tap state moved without a rising test clock");

endmodule // stc_scan_tap

`default_nettype wire

/* inc/stc_pkg.sv */
// Purpose: shared constants and types for the scan tap signature/count block
// Assumes: tap pins are sampled by the system clock, never used as a clock
// Notes:   opcodes other than capture and bypass are free choices here
`default_nettype none

package stc_pkg;

    // widths
    localparam int unsigned IR_W   = 8;
    localparam int unsigned SIG_W  = 20;
    localparam int unsigned BSR_W  = 40;
    localparam int unsigned TCR_W  = 3;
    localparam int unsigned SYN_W  = 45;

    // bit positions inside the sampled pin vector
    localparam int unsigned POS_A    = 0;
    localparam int unsigned POS_B    = 20;
    localparam int unsigned POS_B_TO_A_OUTPUT_ENABLE = 40;
    localparam int unsigned POS_A_TO_B_OUTPUT_ENABLE = 41;
    localparam int unsigned POS_TDI  = 42;
    localparam int unsigned POS_TMS  = 43;
    localparam int unsigned POS_TCK  = 44;

    // instruction codes; run, read and control values are arbitrary
    localparam logic [IR_W-1:0] IR_CAPTURE  = 8'h81;
    localparam logic [IR_W-1:0] IR_BYPASS   = 8'hff;
    localparam logic [IR_W-1:0] IR_RUN_TEST = 8'h09;
    localparam logic [IR_W-1:0] IR_BND_READ = 8'h07;
    localparam logic [IR_W-1:0] IR_TCR_SCAN = 8'h11;

    // test control codes and signature feedback taps
    localparam logic [TCR_W-1:0] TCR_SIG_COUNT = 3'h7;
    localparam logic [SIG_W-1:0] SIG_TAPS      = 20'h00009;

    // values after reset
    localparam logic [SYN_W-1:0] SYN_RST = 45'h0;
    localparam logic [BSR_W-1:0] BSR_RST = 40'h0;
    localparam logic [TCR_W-1:0] TCR_RST = 3'h0;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
        TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
    } stc_tap_e;

    // tap state walk for one rising test clock
    function automatic stc_tap_e stc_tap_next(input stc_tap_e s,
                                              input logic tms);
        stc_tap_e n;
        n = s;
        unique case (s)
            TAP_RESET:    n = tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:     n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:   n = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR:   n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:    n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR:   n = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: n = tms ? TAP_EX2_DR : TAP_PAUSE_DR;
            TAP_EX2_DR:   n = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR:   n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:   n = tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR:   n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:    n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR:   n = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: n = tms ? TAP_EX2_IR : TAP_PAUSE_IR;
            TAP_EX2_IR:   n = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR:   n = tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
        return n;
    endfunction

    // per-bit glitch filter: take a new level once two stages agree
    function automatic logic [SYN_W-1:0] stc_agree(
        input logic [SYN_W-1:0] s2, input logic [SYN_W-1:0] s3,
        input logic [SYN_W-1:0] q);
        return (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    endfunction

endpackage

`default_nettype wire

/* rtl/stc_skid2.sv */
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   ready in is high only while a slot is free
`default_nettype none

module stc_skid2 #(
    parameter int unsigned W = 20
) (
    // clock and reset
    input  wire  logic         sys_clk_i,
    input  wire  logic         sys_rst_i,
    // fill side
    input  wire  logic         in_valid_i,
    output logic               in_ready_o,
    input  wire  logic [W-1:0] in_data_i,
    // drain side
    output logic               out_valid_o,
    input  wire  logic         out_ready_i,
    output logic [W-1:0]       out_data_o
);

    logic [W-1:0] e0_r, e0_nxt;
    logic [W-1:0] e1_r, e1_nxt;
    logic [1:0]   cnt_r, cnt_nxt;
    logic         push;
    logic         pop;

    assign in_ready_o  = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o  = e0_r;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        e0_nxt  = e0_r;
        e1_nxt  = e1_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            if (cnt_r == 2'h0) begin
                e0_nxt = in_data_i;
            end else begin
                e1_nxt = in_data_i;
            end
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            e0_nxt  = e1_r;
            cnt_nxt = cnt_r - 2'h1;
        end else if (pop && push) begin
            // one entry with a pop: the new word takes the head slot
            if (cnt_r == 2'h1) begin
                e0_nxt = in_data_i;
            end else begin
                e0_nxt = e1_r;
                e1_nxt = in_data_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            e0_r  <= '0;
            e1_r  <= '0;
            cnt_r <= 2'h0;
        end else begin
            e0_r  <= e0_nxt;
            e1_r  <= e1_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule // stc_skid2

`default_nettype wire

/* dv/stc_tap_ctrl.sv */
// Purpose: test controller model that drives the tap pins, 800 ns per tck
// Assumes: tck rests high between steps; tms and tdi move on the fall
// Notes:   tdi shows the inverse of its last value when not meaningful
`default_nettype none

module stc_tap_ctrl
    import stc_pkg::*;
(
    // clock
    input  wire logic sys_clk_i,
    // tap pins
    output var  logic tck_o,
    output var  logic tms_o,
    output var  logic tdi_o,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i
);
    timeunit 1ns;
    timeprecision 1ns;

    logic tdo_q;
    logic oe_q;

    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        tdo_q = 1'b0;
        oe_q  = 1'b0;
    end

    // one tck period: fall, 4 clocks low, rise, 4 clocks high
    task automatic step(input logic tms_v, input logic tdi_v,
                        input logic vld);
        @(posedge sys_clk_i);
        tck_o <= 1'b0;
        tms_o <= tms_v;
        tdi_o <= vld ? tdi_v : ~tdi_o;
        repeat (4) @(posedge sys_clk_i);
        tck_o <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        tdo_q = tdo_i;
        oe_q  = tdo_oe_i;
    endtask

    // n bits lsb first, idle to idle; a seed goes in this way too
    task automatic scan(input logic ir, input int n,
                        input logic [BSR_W-1:0] d,
                        output logic [BSR_W-1:0] q,
                        output logic oe_all, output logic oe_end);
        q      = 40'h0;
        oe_all = 1'b1;
        step(1'b1, 1'b0, 1'b0);
        if (ir)
            step(1'b1, 1'b0, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], 1'b1);
            q[i]   = tdo_q;
            oe_all = oe_all & oe_q;
        end
        step(1'b1, 1'b0, 1'b0);
        oe_end = oe_q;
        step(1'b0, 1'b0, 1'b0);
    endtask
endmodule // stc_tap_ctrl

`default_nettype wire

/* dv/stc_scan_tap_tb.sv */
// Purpose: self-checking bench for the scan tap signature/count block
// Assumes: controller model owns tck, tms, tdi; bench owns pins and stream
// Notes:   a stalled stream freezes signature and count, so both are modelled
`default_nettype none

module stc_scan_tap_tb
    import stc_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;

    logic             sys_clk;
    logic             sys_rst;
    logic             tck;
    logic             tms;
    logic             tdi;
    logic             tdo;
    logic             tdo_oe;
    logic             a_to_b_output_enable_n;
    logic             b_to_a_output_enable_n;
    logic [SIG_W-1:0] drv;
    logic [SIG_W-1:0] a_o, a_oe, a_w, b_o, b_oe, b_w;
    logic             sig_valid;
    logic             sig_ready;
    logic [SIG_W-1:0] sig_data;
    logic [SIG_W-1:0] sig_m;
    logic [SIG_W-1:0] cnt_m;
    logic [SIG_W-1:0] exp_q[$];
    logic [SIG_W-1:0] got_q[$];
    logic [BSR_W-1:0] q;
    logic             oe_all;
    logic             oe_end;
    logic [41:0]      last_out;
    int               pend;
    int               hi_cnt;
    int               failures;
    int               n_compared;

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // wire level: the block wins where it drives, else the bench value
    assign a_w = (a_oe & a_o) | (~a_oe & drv);
    assign b_w = (b_oe & b_o) | (~b_oe & drv);

    stc_scan_tap i_stc_scan_tap (
        .sys_clk_i                (sys_clk),
        .sys_rst_i                (sys_rst),
        .tck_i                    (tck),
        .tms_i                    (tms),
        .tdi_i                    (tdi),
        .tdo_o                    (tdo),
        .tdo_oe_o                 (tdo_oe),
        .a_to_b_output_enable_n_i (a_to_b_output_enable_n),
        .b_to_a_output_enable_n_i (b_to_a_output_enable_n),
        .a_pin_i                  (a_w),
        .a_pin_o                  (a_o),
        .a_pin_oe_o               (a_oe),
        .b_pin_i                  (b_w),
        .b_pin_o                  (b_o),
        .b_pin_oe_o               (b_oe),
        .sig_valid_o              (sig_valid),
        .sig_ready_i              (sig_ready),
        .sig_data_o               (sig_data)
    );

    stc_tap_ctrl i_stc_tap_ctrl (
        .sys_clk_i (sys_clk),
        .tck_o     (tck),
        .tms_o     (tms),
        .tdi_o     (tdi),
        .tdo_i     (tdo),
        .tdo_oe_i  (tdo_oe)
    );

    task automatic fail(input string msg);
        failures++;
        $display("[FAIL] %0t ns %s", $time, msg);
    endtask

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
            fail(msg);
    endtask

    task automatic wrap_up();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // consumer pops words; outputs must hold through the tck high phase
    always @(posedge sys_clk) begin
        if (sig_valid === 1'b1 && sig_ready === 1'b1)
            got_q.push_back(sig_data);
        if (hi_cnt >= 1 && {tdo, tdo_oe, a_o, b_o} !== last_out)
            fail("output moved while tck high");
        hi_cnt   <= (tck === 1'b1) ? hi_cnt + 1 : 0;
        last_out <= {tdo, tdo_oe, a_o, b_o};
    end

    task automatic model();
        sig_m = {sig_m[SIG_W-2:0], ^(sig_m & SIG_TAPS)} ^ drv;
        cnt_m = cnt_m + 20'h00001;
        exp_q.push_back(sig_m);
    endtask

    task automatic run(input int n, input logic ab, input logic live,
                       input logic act);
        logic adv;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            drv <= 20'h5a3c1 ^ (20'h00001 << i) ^ cnt_m;
            i_stc_tap_ctrl.step(1'b0, 1'b0, 1'b0);
            chk((ab ? b_oe : a_oe) === {SIG_W{live}}, "count oe");
            chk((ab ? a_oe : b_oe) === 20'h00000, "signature oe");
            if (act)
                chk((ab ? b_o : a_o) === cnt_m, "count pins");
            adv = act && (sig_ready === 1'b1 || pend < 2);
            if (sig_ready !== 1'b1)
                pend += adv;
            if (adv)
                model();
        end
    endtask

    task automatic sig_count(input logic ab, input logic [TCR_W-1:0] code,
                             input logic live);
        logic act;
        act   = live && code == TCR_SIG_COUNT;
        sig_m = 20'h0c3a5;
        cnt_m = 20'hffffd;
        exp_q = {};
        got_q = {};
        pend  = 0;
        @(posedge sys_clk);
        a_to_b_output_enable_n <= !(live && ab);
        b_to_a_output_enable_n <= !(live && !ab);
        i_stc_tap_ctrl.scan(1'b1, IR_W, {32'h0, IR_TCR_SCAN},
                            q, oe_all, oe_end);
        i_stc_tap_ctrl.scan(1'b0, TCR_W, {37'h0, code},
                            q, oe_all, oe_end);
        i_stc_tap_ctrl.scan(1'b1, IR_W, {32'h0, IR_BND_READ},
                            q, oe_all, oe_end);
        i_stc_tap_ctrl.scan(1'b0, BSR_W, ab ? {cnt_m, sig_m} : {sig_m, cnt_m},
                            q, oe_all, oe_end);
        chk({b_o, a_o} === (ab ? {cnt_m, sig_m} : {sig_m, cnt_m}),
            "update to pins");
        i_stc_tap_ctrl.scan(1'b1, IR_W, {32'h0, IR_RUN_TEST},
                            q, oe_all, oe_end);
        @(posedge sys_clk);
        sig_ready <= 1'b1;
        run(4, ab, live, act);
        // let the last word pop before the stall, so two slots are free
        repeat (2) @(posedge sys_clk);
        sig_ready <= 1'b0;
        run(3, ab, live, act);
        chk(sig_valid === act, "words held while stalled");
        @(posedge sys_clk);
        sig_ready <= 1'b1;
        for (int i = 0; i < 20 && sig_valid !== 1'b0; i++)
            @(posedge sys_clk);
        @(negedge sys_clk);
        chk(sig_valid === 1'b0, "stream drained");
        pend = 0;
        // the rise that leaves idle is still a run step
        if (act)
            model();
        i_stc_tap_ctrl.scan(1'b1, IR_W, {32'h0, IR_BND_READ},
                            q, oe_all, oe_end);
        i_stc_tap_ctrl.scan(1'b0, BSR_W, 40'h0, q, oe_all, oe_end);
        chk(q === (ab ? {cnt_m, sig_m} : {sig_m, cnt_m}),
            "signature and count readback");
        chk(got_q.size() == exp_q.size(), "word count");
        foreach (exp_q[i])
            chk(got_q[i] === exp_q[i], "signature word");
        $display("test sig_count ab=%0b code=%0h live=%0b done",
                 ab, code, live);
    endtask

    task automatic bypass_test();
        i_stc_tap_ctrl.scan(1'b1, IR_W, {32'h0, IR_BYPASS}, q, oe_all, oe_end);
        chk(q[7:0] === 8'h81, "ir capture pattern");
        chk(oe_all === 1'b1 && oe_end === 1'b0, "ir tdo enable");
        i_stc_tap_ctrl.scan(1'b0, 3, 40'h5, q, oe_all, oe_end);
        chk(q[2:0] === 3'h2, "bypass delay");
        chk(oe_all === 1'b1 && oe_end === 1'b0, "dr tdo enable");
        $display("test bypass done");
    endtask

    initial begin
        sys_rst                = 1'b1;
        drv                    = 20'h00000;
        sig_ready              = 1'b0;
        a_to_b_output_enable_n = 1'b1;
        b_to_a_output_enable_n = 1'b1;
        hi_cnt                 = 0;
        pend                   = 0;
        failures               = 0;
        n_compared             = 0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(tdo_oe === 1'b0 && sig_valid === 1'b0 && {a_oe, b_oe} === 40'h0,
            "reset outputs");
        i_stc_tap_ctrl.step(1'b0, 1'b0, 1'b0);
        sig_count(1'b1, TCR_SIG_COUNT, 1'b1);
        sig_count(1'b0, TCR_SIG_COUNT, 1'b1);
        sig_count(1'b1, 3'h3, 1'b1);
        sig_count(1'b0, TCR_SIG_COUNT, 1'b0);
        bypass_test();
        wrap_up();
    end

    // about 5500 clocks expected; over seven times that means a hang
    initial begin
        repeat (40000) @(posedge sys_clk);
        fail("watchdog expired");
        wrap_up();
    end
endmodule // stc_scan_tap_tb

`default_nettype wire
